// ### rtl/fps_pkg.sv
/*
 Constants shared by the transmit pulse sequencer: field widths, divider codes,
 output selection bit positions and the noise generator seed and taps.
 Assumes a single clock domain; no other package is needed.
*/
// Summary of operation
// - Pulse input clock comes from high-speed clock after its configured divider.
// - Input clock is doubled, then divided by divider setting plus one.
// - Exactly the programmed number of pulses, one to 127, per burst.
// - A pulse count of zero disables the generator; no pulses.
// - Phase bits apply per pulse from the LSB in bursts of up to 15 pulses; zero high-low, one low-high.
// - A time-of-flight start command begins a burst.
// - With start select set, the pulse also starts the converter.
// - Idle level zero floats inactive outputs; one drives them to ground.
// - Each pulse takes two reference periods: one high, one low.
// - Both-outputs selection drives down-stream output inverted from up-stream.
// - Up or down selection enables one output; restart alternates from it.
// - Phase-shift control adds phase noise to pulse timing.
// - Mode 1 fast init re-arms the converter when the interrupt rises.
// - Start-noise enable adds a random offset to the start event.
package fps_pkg;
  localparam int unsigned FPS_COUNT_W = 7;
  localparam int unsigned FPS_PHASE_W = 16;
  localparam int unsigned FPS_DIV_W = 4;
  localparam int unsigned FPS_HSDIV_W = 2;
  localparam int unsigned FPS_IDX_W = 7;
  localparam int unsigned FPS_LEAD_W = 4;
  localparam int unsigned FPS_SNOISE_W = 3;
  localparam int unsigned FPS_LFSR_W = 16;

  // Output selection bit positions inside output_config (bits 29..31 upstream)
  localparam int unsigned FPS_CFG_DOWN = 0;
  localparam int unsigned FPS_CFG_UP = 1;
  localparam int unsigned FPS_CFG_BOTH = 2;

  // Largest burst that honours a per-pulse phase pattern
  localparam logic [FPS_COUNT_W-1:0] FPS_PHASE_MAX = 7'h0F;
  localparam logic [FPS_COUNT_W-1:0] FPS_COUNT_OFF = 7'h00;

  // Doubled-clock period in clk_in cycles per divider code: /1, /2, /4, /4
  localparam logic [1:0] FPS_HS_MASK_1 = 2'h0;
  localparam logic [1:0] FPS_HS_MASK_2 = 2'h1;
  localparam logic [1:0] FPS_HS_MASK_4 = 2'h3;
  localparam logic [FPS_HSDIV_W-1:0] FPS_HS_DIV1 = 2'h0;
  localparam logic [FPS_HSDIV_W-1:0] FPS_HS_DIV2 = 2'h1;

  localparam logic [FPS_LFSR_W-1:0] FPS_LFSR_SEED = 16'hACE1;
  localparam logic [FPS_LFSR_W-1:0] FPS_LFSR_TAPS = 16'hB400;

  typedef enum logic [2:0] {
    FPS_IDLE = 3'h1,
    FPS_LEAD = 3'h2,
    FPS_PULSE = 3'h4
  } fps_state_t;
endpackage

// ### rtl/fps_noise_lfsr.sv
/*
 Free-running Galois LFSR feeding the phase and start noise of the sequencer.
 Assumes clk_in and the synchronous active-low reset of the sequencer.
*/
`timescale 1ns/1ps
module fps_noise_lfsr (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic [fps_pkg::FPS_LFSR_W-1:0] value_out
);
  import fps_pkg::*;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      value_out <= FPS_LFSR_SEED;
    end else if (value_out[0]) begin
      value_out <= (value_out >> 1) ^ FPS_LFSR_TAPS;
    end else begin
      value_out <= value_out >> 1;
    end
  end

  a_lfsr_nonzero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    value_out != '0) else $error("noise generator stuck at zero");
endmodule

// ### rtl/fps_sequencer.sv
/*
 Transmit pulse sequencer: burst of up/down transducer pulses, converter start
 and fast re-initialisation. clk_in runs at twice the high-speed clock.
 Assumes commands, interrupt flag and settings come from logic on clk_in.
*/
`timescale 1ns/1ps
module fps_sequencer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [fps_pkg::FPS_HSDIV_W-1:0] hs_clock_divider_in,
  input wire logic [fps_pkg::FPS_DIV_W-1:0] pulse_divider_in,
  input wire logic [fps_pkg::FPS_COUNT_W-1:0] pulse_count_in,
  input wire logic [fps_pkg::FPS_PHASE_W-1:0] pulse_phase_pattern_in,
  input wire logic [2:0] output_config_in,
  input wire logic start_select_in,
  input wire logic idle_ground_in,
  input wire logic phase_shift_noise_ctrl_in,
  input wire logic start_noise_enable_in,
  input wire logic fast_init_enable_in,
  input wire logic meas_mode1_in,
  input wire logic irq_flag_in,
  input wire logic tof_start_command_in,
  input wire logic tof_alternating_start_command_in,
  output logic fire_up_out,
  output logic fire_up_oe_n_out,
  output logic fire_down_out,
  output logic fire_down_oe_n_out,
  output logic tdc_start_out,
  output logic tdc_reinit_out,
  output logic busy_out
);
  import fps_pkg::*;

  fps_state_t state;
  logic [FPS_LFSR_W-1:0] noise;
  logic [1:0] hs_cnt;
  logic [1:0] hs_mask;
  logic dbl_tick;
  logic [FPS_DIV_W-1:0] div;
  logic [FPS_DIV_W-1:0] ref_cnt;
  logic ref_tick;
  logic [FPS_COUNT_W-1:0] count;
  logic [FPS_PHASE_W-1:0] pattern;
  logic [FPS_IDX_W-1:0] idx;
  logic half;
  logic en_up;
  logic en_down;
  logic both;
  logic use_start;
  logic alt_second;
  logic [FPS_LEAD_W-1:0] lead_cnt;
  logic snoise_pend;
  logic [FPS_SNOISE_W-1:0] snoise_cnt;
  logic irq_prev;
  logic go;
  logic start_req;
  logic phase_bit;
  logic level;
  logic last_pulse;

  fps_noise_lfsr u_noise (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .value_out(noise)
  );

  // Doubled pulse input clock: a tick every 1, 2 or 4 clk_in cycles
  always_comb begin
    case (hs_clock_divider_in)
      FPS_HS_DIV1: hs_mask = FPS_HS_MASK_1;
      FPS_HS_DIV2: hs_mask = FPS_HS_MASK_2;
      default: hs_mask = FPS_HS_MASK_4;
    endcase
  end
  assign dbl_tick = (hs_cnt & hs_mask) == hs_mask;

  // Divider phase restarts as the pulses begin, so the first half is full length
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || dbl_tick || state == FPS_IDLE) begin
      hs_cnt <= '0;
    end else if (state == FPS_LEAD && lead_cnt == '0) begin
      hs_cnt <= '0;
    end else begin
      hs_cnt <= hs_cnt + 2'h1;
    end
  end

  // Reference tick every div+1 doubled ticks; restarted at each burst
  assign ref_tick = dbl_tick && (ref_cnt == div);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || state != FPS_PULSE || ref_tick) begin
      ref_cnt <= '0;
    end else if (dbl_tick) begin
      ref_cnt <= ref_cnt + 4'h1;
    end
  end

  assign start_req = tof_start_command_in || tof_alternating_start_command_in;
  assign go = state == FPS_IDLE && start_req && pulse_count_in != FPS_COUNT_OFF;

  // Burst settings latched at the start so mid-burst writes do no harm
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count <= FPS_COUNT_OFF;
      pattern <= '0;
      div <= '0;
      en_up <= 1'b0;
      en_down <= 1'b0;
      both <= 1'b0;
      use_start <= 1'b0;
    end else if (go) begin
      count <= pulse_count_in;
      pattern <= (pulse_count_in <= FPS_PHASE_MAX) ? pulse_phase_pattern_in : '0;
      div <= pulse_divider_in;
      both <= output_config_in[FPS_CFG_BOTH];
      use_start <= start_select_in;
      if (output_config_in[FPS_CFG_BOTH]) begin
        en_up <= 1'b1;
        en_down <= 1'b1;
      end else begin
        // Alternate only on the restart command
        en_up <= output_config_in[FPS_CFG_UP] ^ (tof_alternating_start_command_in
          && alt_second);
        en_down <= output_config_in[FPS_CFG_DOWN] ^ (tof_alternating_start_command_in
          && alt_second);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      alt_second <= 1'b0;
    end else if (go && tof_alternating_start_command_in) begin
      alt_second <= !alt_second;
    end else if (go) begin
      alt_second <= 1'b0;
    end
  end

  assign last_pulse = idx == count - 7'h01;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= FPS_IDLE;
      lead_cnt <= '0;
      idx <= '0;
      half <= 1'b0;
    end else begin
      case (state)
        FPS_IDLE: begin
          idx <= '0;
          half <= 1'b0;
          if (go) begin
            state <= FPS_LEAD;
            // Control low means the phase shift is active
            lead_cnt <= phase_shift_noise_ctrl_in ? '0 : noise[FPS_LEAD_W-1:0];
          end
        end
        FPS_LEAD: begin
          if (lead_cnt == '0) begin
            state <= FPS_PULSE;
          end else if (dbl_tick) begin
            lead_cnt <= lead_cnt - 4'h1;
          end
        end
        FPS_PULSE: begin
          if (ref_tick) begin
            half <= !half;
            if (half && last_pulse) begin
              state <= FPS_IDLE;
            end else if (half) begin
              idx <= idx + 7'h01;
            end
          end
        end
        default: state <= FPS_IDLE;
      endcase
    end
  end

  assign phase_bit = (idx < FPS_IDX_W'(FPS_PHASE_W)) ?
    pattern[idx[$clog2(FPS_PHASE_W)-1:0]] : 1'b0;
  assign level = half ? phase_bit : !phase_bit;

  // Registered pin drive; idle level applies when not firing
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fire_up_out <= 1'b0;
      fire_down_out <= 1'b0;
      fire_up_oe_n_out <= 1'b1;
      fire_down_oe_n_out <= 1'b1;
    end else if (state == FPS_PULSE) begin
      fire_up_out <= en_up && level;
      fire_down_out <= en_down && (both ? !level : level);
      fire_up_oe_n_out <= !(en_up || idle_ground_in);
      fire_down_oe_n_out <= !(en_down || idle_ground_in);
    end else begin
      fire_up_out <= 1'b0;
      fire_down_out <= 1'b0;
      fire_up_oe_n_out <= !idle_ground_in;
      fire_down_oe_n_out <= !idle_ground_in;
    end
  end

  // Converter start at the first pulse edge, optionally randomly delayed
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      snoise_pend <= 1'b0;
      snoise_cnt <= '0;
      tdc_start_out <= 1'b0;
    end else begin
      tdc_start_out <= 1'b0;
      if (state == FPS_LEAD && lead_cnt == '0 && use_start) begin
        snoise_pend <= 1'b1;
        snoise_cnt <= start_noise_enable_in ? noise[FPS_LEAD_W +: FPS_SNOISE_W] : '0;
      end else if (snoise_pend && snoise_cnt == '0) begin
        snoise_pend <= 1'b0;
        tdc_start_out <= 1'b1;
      end else if (snoise_pend) begin
        snoise_cnt <= snoise_cnt - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_prev <= 1'b0;
      tdc_reinit_out <= 1'b0;
    end else begin
      irq_prev <= irq_flag_in;
      tdc_reinit_out <= meas_mode1_in && fast_init_enable_in && irq_flag_in && !irq_prev;
    end
  end

  assign busy_out = state != FPS_IDLE;

  a_zero_count_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == FPS_IDLE && pulse_count_in == FPS_COUNT_OFF |=> state == FPS_IDLE)
    else $error("burst started with zero pulse count");
  a_start_leaves_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    go |=> state == FPS_LEAD) else $error("start command not taken");
  a_burst_length: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == FPS_PULSE && $past(state) == FPS_PULSE |-> idx < count)
    else $error("pulse index ran past the count");
  a_end_on_last: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == FPS_PULSE ##1 state == FPS_IDLE |-> $past(last_pulse) && $past(half))
    else $error("burst ended early");
  a_half_on_tick: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == FPS_PULSE && $changed(half) |-> $past(ref_tick))
    else $error("phase changed without reference tick");
  a_ref_divide: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ref_tick && div != '0 |=> !ref_tick) else $error("reference divide below two");
  a_idle_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == FPS_IDLE |=> !fire_up_out && fire_up_oe_n_out == !$past(idle_ground_in))
    else $error("idle level wrong");
  a_both_inverted: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == FPS_PULSE && both |=> fire_down_out == !fire_up_out)
    else $error("down output not inverted");
  a_start_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tdc_start_out |-> use_start) else $error("converter start while not selected");
  a_reinit_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    meas_mode1_in && fast_init_enable_in && $rose(irq_flag_in) |=> tdc_reinit_out)
    else $error("fast init missed");
endmodule

// ### verification/fps_transducer_model.sv
/*
 Transducer model for one fire pin: counts cycles driven high since clear.
 Assumes pin data and enable registered on clk_in; floating pin gives no drive.
*/
`timescale 1ns/1ps
module fps_transducer_model (
  input wire logic clk_in,
  input wire logic clear_in,
  input wire logic drive_in,
  input wire logic oe_n_in,
  output logic [15:0] high_out,
  output logic [15:0] first_out
);
  logic [15:0] age;
  logic seen;
  always_ff @(posedge clk_in) begin
    if (clear_in) begin
      age <= 16'h0000;
      seen <= 1'b0;
      high_out <= 16'h0000;
      first_out <= 16'hFFFF;
    end else begin
      age <= age + 16'h0001;
      // Only a driven high excites the transducer
      if (!oe_n_in && drive_in) begin
        high_out <= high_out + 16'h0001;
        if (!seen) begin
          first_out <= age;
          seen <= 1'b1;
        end
      end
    end
  end
endmodule

// ### verification/fps_sequencer_tb.sv
/*
 Self-checking bench for the transmit pulse sequencer.
 Assumes one transducer model per fire pin; noise off unless a case says so.
*/
`timescale 1ns/1ps
module fps_sequencer_tb;
  import fps_pkg::*;
  typedef struct packed {
    logic [6:0] c;
    logic [15:0] p;
    logic [2:0] cf;
    logic [3:0] d;
    logic [1:0] h;
    logic [15:0] up;
    logic [15:0] dn;
  } fps_row_t;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] hs_clock_divider_in = 2'h0;
  logic [3:0] pulse_divider_in = 4'h1;
  logic [6:0] pulse_count_in = 7'h00;
  logic [15:0] pulse_phase_pattern_in = 16'h0000;
  logic [2:0] output_config_in = 3'h2;
  logic start_select_in = 1'b1;
  logic idle_ground_in = 1'b1;
  logic phase_shift_noise_ctrl_in = 1'b1;
  logic start_noise_enable_in = 1'b0;
  logic fast_init_enable_in = 1'b1;
  logic meas_mode1_in = 1'b1;
  logic irq_flag_in = 1'b0;
  logic tof_start_command_in = 1'b0;
  logic tof_alternating_start_command_in = 1'b0;
  logic fire_up_out, fire_up_oe_n_out, fire_down_out, fire_down_oe_n_out;
  logic tdc_start_out, tdc_reinit_out, busy_out, seen;
  logic clear = 1'b1;
  logic [31:0] hi, fst;
  logic [15:0] f0;
  int err_total = 0;
  int tests_run = 0;
  int starts = 0;
  int reinits = 0;
  // Count ranges phase only up to 15 pulses, top bit zero
  fps_row_t rows[7] = '{
    '{7'h01, 16'h0000, 3'h2, 4'h1, 2'h0, 16'h0002, 16'h0000},
    '{7'h7F, 16'h0000, 3'h2, 4'hF, 2'h0, 16'h07F0, 16'h0000},
    '{7'h0F, 16'h5555, 3'h1, 4'h2, 2'h0, 16'h0000, 16'h002D},
    '{7'h0E, 16'h2AAA, 3'h4, 4'h1, 2'h0, 16'h001C, 16'h001C},
    '{7'h02, 16'h0000, 3'h2, 4'h1, 2'h1, 16'h0008, 16'h0000},
    '{7'h01, 16'h0001, 3'h2, 4'h1, 2'h2, 16'h0008, 16'h0000},
    '{7'h14, 16'h0000, 3'h2, 4'h1, 2'h0, 16'h0028, 16'h0000}};

  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    starts <= clear ? 0 : starts + int'(tdc_start_out);
    reinits <= clear ? 0 : reinits + int'(tdc_reinit_out);
  end

  fps_sequencer fps_sequencer_inst (.clk_in, .rst_n_in, .hs_clock_divider_in,
    .pulse_divider_in, .pulse_count_in, .pulse_phase_pattern_in, .output_config_in,
    .start_select_in, .idle_ground_in, .phase_shift_noise_ctrl_in, .start_noise_enable_in,
    .fast_init_enable_in, .meas_mode1_in, .irq_flag_in, .tof_start_command_in,
    .tof_alternating_start_command_in, .fire_up_out, .fire_up_oe_n_out, .fire_down_out,
    .fire_down_oe_n_out, .tdc_start_out, .tdc_reinit_out, .busy_out);
  fps_transducer_model fps_transducer_model_inst[1:0] (.clk_in, .clear_in(clear),
    .drive_in({fire_down_out, fire_up_out}),
    .oe_n_in({fire_down_oe_n_out, fire_up_oe_n_out}), .high_out(hi), .first_out(fst));

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_in);
    #5;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Mode bit 0 picks the alternating command, bit 1 retriggers while busy
  task automatic burst(input logic [6:0] c, input logic [15:0] p, input logic [2:0] cf,
    input logic [3:0] d, input logic [1:0] h, input logic [1:0] m);
    int k;
    pulse_count_in = c;
    pulse_phase_pattern_in = p;
    output_config_in = cf;
    pulse_divider_in = d;
    hs_clock_divider_in = h;
    clear = 1'b1;
    tick();
    clear = 1'b0;
    tof_alternating_start_command_in = m[0];
    tof_start_command_in = !m[0];
    tick();
    tof_alternating_start_command_in = 1'b0;
    tof_start_command_in = 1'b0;
    seen = busy_out;
    if (m[1]) begin
      tick(2);
      tof_start_command_in = 1'b1;
      tick();
      tof_start_command_in = 1'b0;
    end
    k = 0;
    while (busy_out !== 1'b0 && k < 6000) begin
      tick();
      k++;
    end
    if (k == 6000) begin
      err_total++;
      $display("FAIL %0t burst did not finish", $time);
      wrap_up();
    end
    tick(4);
  endtask

  initial begin
    tick(15);
    chk(16'({fire_up_out, fire_up_oe_n_out, fire_down_out, fire_down_oe_n_out, busy_out}),
      16'h000A);
    tick();
    rst_n_in = 1'b1;
    tick(2);
    chk(16'({fire_up_oe_n_out, fire_down_oe_n_out}), 16'h0000);
    idle_ground_in = 1'b0;
    tick(2);
    chk(16'({fire_up_oe_n_out, fire_down_oe_n_out}), 16'h0003);
    idle_ground_in = 1'b1;
    foreach (rows[i]) begin
      burst(rows[i].c, rows[i].p, rows[i].cf, rows[i].d, rows[i].h, 2'h0);
      chk(hi[15:0], rows[i].up);
      chk(hi[31:16], rows[i].dn);
      chk(16'(starts), 16'h0001);
      chk(16'({fire_up_out, fire_down_out}), 16'h0000);
    end
    burst(7'h00, 16'h0000, 3'h2, 4'h1, 2'h0, 2'h0);
    chk(16'(seen), 16'h0000);
    chk(hi[15:0] | hi[31:16], 16'h0000);
    burst(7'h04, 16'h0000, 3'h2, 4'h1, 2'h0, 2'h2);
    chk(hi[15:0], 16'h0008);
    burst(7'h01, 16'h0000, 3'h2, 4'h1, 2'h0, 2'h1);
    chk(hi[15:0], 16'h0002);
    burst(7'h01, 16'h0000, 3'h2, 4'h1, 2'h0, 2'h1);
    chk(hi[31:16], 16'h0002);
    burst(7'h01, 16'h0000, 3'h2, 4'h1, 2'h0, 2'h0);
    burst(7'h01, 16'h0000, 3'h2, 4'h1, 2'h0, 2'h1);
    chk(hi[15:0], 16'h0002);
    burst(7'h01, 16'h0000, 3'h2, 4'h3, 2'h0, 2'h0);
    f0 = fst[15:0];
    burst(7'h01, 16'h0001, 3'h2, 4'h3, 2'h0, 2'h0);
    chk(fst[15:0] - f0, 16'h0004);
    start_select_in = 1'b0;
    burst(7'h02, 16'h0000, 3'h2, 4'h1, 2'h0, 2'h0);
    chk(16'(starts), 16'h0000);
    start_select_in = 1'b1;
    phase_shift_noise_ctrl_in = 1'b0;
    start_noise_enable_in = 1'b1;
    burst(7'h05, 16'h0000, 3'h2, 4'h1, 2'h0, 2'h0);
    chk(hi[15:0], 16'h000A);
    chk(16'(starts), 16'h0001);
    irq_flag_in = 1'b1;
    tick(3);
    chk(16'(reinits), 16'h0001);
    irq_flag_in = 1'b0;
    fast_init_enable_in = 1'b0;
    tick();
    irq_flag_in = 1'b1;
    tick(3);
    chk(16'(reinits), 16'h0001);
    // Reset in the middle of a burst must drop everything back to idle
    pulse_count_in = 7'h10;
    tof_start_command_in = 1'b1;
    tick();
    tof_start_command_in = 1'b0;
    tick(6);
    chk(16'(busy_out), 16'h0001);
    rst_n_in = 1'b0;
    tick(2);
    chk(16'({fire_up_out, fire_up_oe_n_out, fire_down_out, fire_down_oe_n_out, busy_out}),
      16'h000A);
    rst_n_in = 1'b1;
    tick(2);
    chk(16'({busy_out, fire_up_oe_n_out, fire_down_oe_n_out}), 16'h0000);
    wrap_up();
  end
endmodule
